//--- src/tsg_channel.sv
// One output channel: sequencing, tracking shutdown, UV/UC blanking
`timescale 1ns/1ns
module tsg_channel (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Control
    input wire logic run_req,
    input wire logic group_down,
    input wire logic hard_down,
    input wire logic track_slave,
    input wire logic [15:0] on_dly,
    input wire logic [15:0] rise_t,
    input wire logic [15:0] off_dly,
    input wire logic monitor_en,
    // Supervisor inputs
    input wire logic uv_raw,
    input wire logic uc_raw,
    // Outputs
    output logic converter_enable_output,
    output logic uv_det,
    output logic uc_det,
    output logic ramping
);
    import tsg_pkg::*;
    tsg_ch_e st_ff, nxt_st; // Channel state
    logic [15:0] cnt_ff, nxt_cnt; // Delay counter
    logic blank; // UV/UC masked
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            CH_OFF: begin
                if (run_req && !group_down && !hard_down) begin
                    nxt_st = CH_ON_DLY;
                    nxt_cnt = on_dly;
                end
            end
            CH_ON_DLY, CH_RISE, CH_ON: begin
                // On group down, slaves sequence down via their off delay, others stop at once
                if (hard_down || (group_down && !track_slave)) begin
                    nxt_st = CH_OFF;
                end else if (group_down || !run_req) begin
                    nxt_st = CH_OFF_DLY;
                    nxt_cnt = off_dly;
                end else if (st_ff == CH_ON_DLY) begin
                    if (cnt_ff == 16'h0000) begin
                        nxt_st = CH_RISE;
                        nxt_cnt = rise_t;
                    end else begin
                        nxt_cnt = cnt_ff - 16'h0001;
                    end
                end else if (st_ff == CH_RISE) begin
                    if (cnt_ff == 16'h0000) begin
                        nxt_st = CH_ON;
                    end else begin
                        nxt_cnt = cnt_ff - 16'h0001;
                    end
                end
            end
            CH_OFF_DLY: begin
                if (hard_down || cnt_ff == 16'h0000) begin
                    nxt_st = CH_OFF;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            default: nxt_st = CH_OFF;
        endcase
    end
    // State registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= CH_OFF;
            cnt_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end
    // Blanking: rise window always, off delay only for slaves
    always_comb begin
        blank = (st_ff == CH_RISE) || (st_ff == CH_ON_DLY) || (st_ff == CH_OFF)
              || (track_slave && st_ff == CH_OFF_DLY);
    end
    // Detections also stopped while monitoring suspended
    assign uv_det = uv_raw && !blank && monitor_en;
    assign uc_det = uc_raw && !blank && monitor_en;
    assign converter_enable_output = (st_ff != CH_OFF);
    assign ramping = (st_ff == CH_RISE);
endmodule // tsg_channel

//--- src/tsg_nvm_seq.sv
// Save and reload sequencer between operating memory and nonvolatile store
`timescale 1ns/1ns
module tsg_nvm_seq #(
    parameter int WORDS = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Requests
    input wire logic save_req,
    input wire logic load_req,
    // Word index, write strobes and busy out
    output logic [3:0] word_idx,
    output logic save_we,
    output logic load_we,
    output logic busy
);
    import tsg_pkg::*;
    tsg_nv_e st_ff, nxt_st; // Sequencer state
    logic [3:0] idx_ff, nxt_idx; // Word pointer
    logic boot_ff, nxt_boot; // Reload after reset pending
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_idx = idx_ff;
        nxt_boot = 1'b0;
        case (st_ff)
            NV_IDLE: begin
                nxt_idx = 4'h0;
                if (boot_ff || load_req) begin
                    nxt_st = NV_LOAD;
                end else if (save_req) begin
                    nxt_st = NV_SAVE;
                end
            end
            NV_SAVE, NV_LOAD: begin
                // One word per cycle, every stored location walked
                if (idx_ff == 4'(WORDS - 1)) begin
                    nxt_st = NV_IDLE;
                end else begin
                    nxt_idx = idx_ff + 4'h1;
                end
            end
            default: nxt_st = NV_IDLE;
        endcase
    end
    // Registers; boot flag forces a reload on leaving reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= NV_IDLE;
            idx_ff <= 4'h0;
            boot_ff <= 1'b1;
        end else begin
            st_ff <= nxt_st;
            idx_ff <= nxt_idx;
            boot_ff <= nxt_boot;
        end
    end
    assign word_idx = idx_ff;
    assign save_we = (st_ff == NV_SAVE);
    assign load_we = (st_ff == NV_LOAD);
    assign busy = (st_ff != NV_IDLE) || boot_ff;
endmodule // tsg_nvm_seq

//--- src/tsg_pkg.sv
// Package: constants, command codes and config field layout for the tracking sequencer
// Function
// - Tracking slaves sequence down on listed causes.
// - Slaves ignore UV/UC during turn-off delay.
// - Always ignore UV/UC during rise and timeout.
// - All tracking channels go off together; here slaves each wait out their own off delay.
// - Global bit picks power-good deassertion source.
// - Per-pin run polarity bit.
// - Fault log written only when enabled.
// - Input-on clears latched faults when enabled.
// - Share-inhibit holds timebase low, turns off.
// - PEC optional unless enable bit set.
// - Long timeout multiplies bus timeout by eight.
// - Aux fault weak pull-up unless disabled.
// - Top four config bits read zero.
// - Config word reachable from any page.
// - Codes 0x15 save, 0x16 reload.
// - Codes 0xbd, 0xbe, 0xbf nonvolatile access.
// - Reload from nonvolatile store after reset.
// - Busy flagged during save or reload.
// - Save copies every stored command value.
// - Monitoring suspended during reload.
// - Busy: status readable, other commands refused.
package tsg_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_CH = 4;
    localparam int CFG_W = 16;
    localparam int NVM_WORDS = 16;
    localparam int NVM_AW = 4;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_SAVE_ALL = 8'h15;
    localparam logic [7:0] CMD_RELOAD_ALL = 8'h16;
    localparam logic [7:0] CMD_NVM_UNLOCK = 8'hbd;
    localparam logic [7:0] CMD_NVM_ERASE = 8'hbe;
    localparam logic [7:0] CMD_NVM_DATA = 8'hbf;
    localparam logic [7:0] CMD_GLOBAL_CFG = 8'hd1; // Code picked locally
    localparam logic [7:0] CMD_COMMON_STAT = 8'hef; // Code picked locally
    // ----------------------------------------
    // Global config fields
    // ----------------------------------------
    localparam int CFG_PGOOD_SEL = 11;
    localparam int CFG_POL3 = 9;
    localparam int CFG_POL2 = 8;
    localparam int CFG_FLOG_EN = 7;
    localparam int CFG_VINON_CLR = 6;
    localparam int CFG_POL1 = 5;
    localparam int CFG_POL0 = 4;
    localparam int CFG_SHARE_INH = 3;
    localparam int CFG_PEC_EN = 2;
    localparam int CFG_LONG_TO = 1;
    localparam int CFG_AUX_WPU_DIS = 0;
    localparam logic [CFG_W-1:0] CFG_WR_MASK = 16'h0fff;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
    localparam logic [7:0] STAT_BUSYN_BIT = 8'h40;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int BUS_TO_US = 25;
    localparam int BUS_TO_CYC = BUS_TO_US * CLK_MHZ;
    localparam int LONG_TO_MUL = 8;
    localparam int NVM_STEP_CYC = 4;
    // ----------------------------------------
    // Channel and save/reload sequencing states
    // ----------------------------------------
    typedef enum logic [4:0] {
        CH_OFF = 5'b00001,
        CH_ON_DLY = 5'b00010,
        CH_RISE = 5'b00100,
        CH_ON = 5'b01000,
        CH_OFF_DLY = 5'b10000
    } tsg_ch_e;
    typedef enum logic [2:0] {
        NV_IDLE = 3'b001,
        NV_SAVE = 3'b010,
        NV_LOAD = 3'b100
    } tsg_nv_e;
endpackage

//--- src/tsg_top.sv
// Top: command decode, global config, tracking group and save/reload
`timescale 1ns/1ns
module tsg_top #(
    parameter int NUM_CH = tsg_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Command port from bus engine
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_pec_present,
    input wire logic cmd_pec_ok,
    input wire logic [1:0] cmd_page,
    output logic cmd_ack,
    output logic cmd_nack,
    output logic [15:0] cmd_rdata,
    // Pins and supervision
    input wire logic [3:0] run_control_pin,
    input wire logic [3:0] uv_raw,
    input wire logic [3:0] uc_raw,
    input wire logic [3:0] fault_in,
    input wire logic vin_above_on,
    input wire logic vin_below_off,
    input wire logic share_clk_in,
    output logic share_clk_oe,
    output logic [3:0] converter_enable_output,
    output logic [3:0] uv_det,
    output logic [3:0] uc_det,
    // Global side outputs
    output logic pgood_deassert_source_sel,
    output logic fault_log_req,
    output logic clear_faults,
    output logic pec_required,
    output logic [15:0] bus_timeout_cyc,
    output logic aux_fault_pu_oe,
    output logic busy
);
    import tsg_pkg::*;
    // ----------------------------------------
    // Configuration storage
    // ----------------------------------------
    logic [CFG_W-1:0] global_config_word_ff, nxt_cfg; // Operating copy
    logic [CFG_W-1:0] nvm_mem [NVM_WORDS]; // Nonvolatile image
    logic [CFG_W-1:0] op_mem_ff [NVM_WORDS]; // Operating words
    logic [CFG_W-1:0] nxt_op [NVM_WORDS];
    logic [7:0] unlock_ff, nxt_unlock; // Unlock key
    logic [7:0] erase_ff, nxt_erase; // Erase key
    logic [15:0] data_ff, nxt_data; // Bulk data
    logic [15:0] rdata_ff, nxt_rdata; // Read data
    logic ack_ff, nxt_ack, nack_ff, nxt_nack;
    logic aux_forced_ff, nxt_aux_forced; // Fault has forced aux low
    logic vin_on_d_ff; // Edge detect on input-on
    logic [3:0] word_idx;
    logic save_we, load_we;
    logic save_req, load_req, accept;
    logic [3:0] run_act;
    logic any_fault, group_down, share_low;
    // PEC gate: required only when enabled
    function automatic logic pec_pass(input logic req, input logic pres, input logic ok);
        pec_pass = req ? (pres && ok) : (!pres || ok);
    endfunction
    // ----------------------------------------
    // Command acceptance
    // ----------------------------------------
    // Busy refuses all but status; page ignored for global word
    assign accept = cmd_valid && (!busy || cmd_code == CMD_COMMON_STAT)
                  && pec_pass(pec_required, cmd_pec_present, cmd_pec_ok);
    assign save_req = accept && !cmd_write && cmd_code == CMD_SAVE_ALL;
    assign load_req = accept && !cmd_write && cmd_code == CMD_RELOAD_ALL;
    // Save/reload sequencer
    tsg_nvm_seq #(.WORDS(NVM_WORDS)) u_nvm (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .save_req(save_req),
        .load_req(load_req),
        .word_idx(word_idx),
        .save_we(save_we),
        .load_we(load_we),
        .busy(busy)
    );
    // Register next values
    always_comb begin
        nxt_cfg = global_config_word_ff;
        nxt_unlock = unlock_ff;
        nxt_erase = erase_ff;
        nxt_data = data_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = 1'b0;
        nxt_nack = cmd_valid && !accept;
        for (int i = 0; i < NVM_WORDS; i++) begin
            nxt_op[i] = op_mem_ff[i];
        end
        nxt_op[0] = global_config_word_ff;
        if (load_we) begin
            nxt_op[word_idx] = nvm_mem[word_idx];
            if (word_idx == 4'h0) begin
                nxt_cfg = nvm_mem[0] & CFG_WR_MASK;
            end
        end
        if (accept) begin
            nxt_ack = 1'b1;
            case (cmd_code)
                CMD_GLOBAL_CFG: begin
                    // Top bits never stored, always read zero
                    if (cmd_write) nxt_cfg = cmd_wdata & CFG_WR_MASK;
                    nxt_rdata = global_config_word_ff & CFG_WR_MASK;
                end
                CMD_NVM_UNLOCK: begin
                    if (cmd_write) nxt_unlock = cmd_wdata[7:0];
                    nxt_rdata = {8'h00, unlock_ff};
                end
                CMD_NVM_ERASE: begin
                    if (cmd_write) nxt_erase = cmd_wdata[7:0];
                    nxt_rdata = {8'h00, erase_ff};
                end
                CMD_NVM_DATA: begin
                    if (cmd_write) nxt_data = cmd_wdata;
                    nxt_rdata = data_ff;
                end
                CMD_COMMON_STAT: begin
                    // Busy flag is active low
                    nxt_rdata = {8'h00, busy ? 8'h00 : STAT_BUSYN_BIT};
                end
                CMD_SAVE_ALL, CMD_RELOAD_ALL: nxt_rdata = rdata_ff;
                default: begin
                    nxt_ack = 1'b0;
                    nxt_nack = 1'b1;
                end
            endcase
        end
    end
    // Config and reply registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            global_config_word_ff <= CFG_RESET;
            unlock_ff <= 8'h00;
            erase_ff <= 8'h00;
            data_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
            ack_ff <= 1'b0;
            nack_ff <= 1'b0;
            vin_on_d_ff <= 1'b1; // No false rise after reset
            aux_forced_ff <= 1'b0;
            for (int i = 0; i < NVM_WORDS; i++) begin
                op_mem_ff[i] <= 16'h0000;
                nvm_mem[i] <= 16'h0000; // Blank store: no retention over power loss
            end
        end else begin
            global_config_word_ff <= nxt_cfg;
            unlock_ff <= nxt_unlock;
            erase_ff <= nxt_erase;
            data_ff <= nxt_data;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            nack_ff <= nxt_nack;
            vin_on_d_ff <= vin_above_on;
            aux_forced_ff <= nxt_aux_forced;
            for (int i = 0; i < NVM_WORDS; i++) begin
                op_mem_ff[i] <= nxt_op[i];
            end
            if (save_we) nvm_mem[word_idx] <= op_mem_ff[word_idx];
        end
    end
    assign cmd_ack = ack_ff;
    assign cmd_nack = nack_ff;
    assign cmd_rdata = rdata_ff;
    // ----------------------------------------
    // Global outputs
    // ----------------------------------------
    assign pgood_deassert_source_sel = global_config_word_ff[CFG_PGOOD_SEL];
    assign pec_required = global_config_word_ff[CFG_PEC_EN];
    // Long timeout stretches the count eightfold
    assign bus_timeout_cyc = global_config_word_ff[CFG_LONG_TO]
                           ? 16'(BUS_TO_CYC * LONG_TO_MUL) : 16'(BUS_TO_CYC);
    assign any_fault = |(fault_in | uv_det | uc_det);
    assign fault_log_req = any_fault && global_config_word_ff[CFG_FLOG_EN];
    // Input rising past its on level clears latched faults
    assign clear_faults = vin_above_on && !vin_on_d_ff
                        && global_config_word_ff[CFG_VINON_CLR];
    // Aux pull-up until a fault forces it off
    assign nxt_aux_forced = aux_forced_ff || any_fault;
    assign aux_fault_pu_oe = !aux_forced_ff && !global_config_word_ff[CFG_AUX_WPU_DIS];
    // ----------------------------------------
    // Tracking group
    // ----------------------------------------
    // Share line inhibit during low input
    assign share_clk_oe = global_config_word_ff[CFG_SHARE_INH]
                        && (!vin_above_on || vin_below_off);
    assign share_low = !share_clk_in && global_config_word_ff[CFG_SHARE_INH];
    // Any down cause takes the whole group down; slaves go off after their off delay
    assign group_down = any_fault || vin_below_off || share_low || load_req || load_we;
    // Run polarity per pin
    assign run_act[0] = run_control_pin[0] ~^ global_config_word_ff[CFG_POL0];
    assign run_act[1] = run_control_pin[1] ~^ global_config_word_ff[CFG_POL1];
    assign run_act[2] = run_control_pin[2] ~^ global_config_word_ff[CFG_POL2];
    assign run_act[3] = run_control_pin[3] ~^ global_config_word_ff[CFG_POL3];
    // Channel timings come from operating words 1..12; slave bits word 13
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tsg_channel u_ch (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .run_req(run_act[g]),
                .group_down(group_down),
                .hard_down(1'b0),
                .track_slave(op_mem_ff[13][g]),
                .on_dly(op_mem_ff[1 + 3 * g]),
                .rise_t(op_mem_ff[2 + 3 * g]),
                .off_dly(op_mem_ff[3 + 3 * g]),
                .monitor_en(!load_we),
                .uv_raw(uv_raw[g]),
                .uc_raw(uc_raw[g]),
                .converter_enable_output(converter_enable_output[g]),
                .uv_det(uv_det[g]),
                .uc_det(uc_det[g]),
                .ramping()
            );
        end
    endgenerate
endmodule // tsg_top

//--- testbench/tsg_conv_model.sv
// Converter model: output ramps after enable, raw supervisor levels back
`timescale 1ns/1ns
module tsg_conv_model #(
    parameter int RAMP = 6
) (
    // Clock
    input wire logic ref_clk,
    // Enables from the block
    input wire logic [3:0] en,
    // Raw supervisor levels
    output logic [3:0] uv_raw,
    output logic [3:0] uc_raw
);
    // ------
    // Output levels
    // ------
    int lvl [4]; // Zero when off; tracking order and slave timings unset
    // Sags at once when disabled, climbs slowly when enabled
    always @(posedge ref_clk) begin
        for (int i = 0; i < 4; i++) begin
            lvl[i] <= en[i] ? ((lvl[i] < RAMP) ? lvl[i] + 1 : RAMP) : 0;
        end
    end
    // Low until ramped, so any missing blanking shows as a detection
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            uv_raw[i] = lvl[i] < RAMP;
            uc_raw[i] = lvl[i] < RAMP;
        end
    end
endmodule // tsg_conv_model

//--- testbench/tsg_top_bench.sv
// Self-checking bench for the tracking sequencer top
`timescale 1ns/1ns
module tsg_top_bench;
    import tsg_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic cmd_write = 1'b0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic cmd_pec_present = 1'b1;
    logic [1:0] cmd_page = 2'h0;
    logic [3:0] run_control_pin = 4'hf;
    logic [3:0] fault_in = 4'h0;
    logic vin_above_on = 1'b1;
    logic share_clk_in, share_oe, cmd_ack, cmd_nack, busy, pgood_sel, flog, clr, pec_req, aux_oe;
    logic [15:0] cmd_rdata, bus_to, d;
    logic [3:0] en, uv_raw, uc_raw;
    logic [31:0] seed = 32'h81586b6b;
    int errors = 0;
    int num_checks = 0;
    int clr_cnt = 0;
    // Open-drain share line with pull-up
    assign share_clk_in = !share_oe;
    tsg_top u_tsg_top (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
        .cmd_pec_present(cmd_pec_present), .cmd_pec_ok(1'b1), .cmd_page(cmd_page),
        .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata),
        .run_control_pin(run_control_pin), .uv_raw(uv_raw), .uc_raw(uc_raw),
        .fault_in(fault_in), .vin_above_on(vin_above_on), .vin_below_off(1'b0),
        .share_clk_in(share_clk_in), .share_clk_oe(share_oe), .converter_enable_output(en),
        .uv_det(), .uc_det(), .pgood_deassert_source_sel(pgood_sel), .fault_log_req(flog),
        .clear_faults(clr), .pec_required(pec_req), .bus_timeout_cyc(bus_to),
        .aux_fault_pu_oe(aux_oe), .busy(busy));
    tsg_conv_model u_tsg_conv_model (.ref_clk(ref_clk), .en(en), .uv_raw(uv_raw),
        .uc_raw(uc_raw));
    // Clock, 10 ns period
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Counts clear pulses
    always @(posedge ref_clk) clr_cnt += int'(clr === 1'b1);
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // Timeout expected from the long bit
    function automatic logic [15:0] exp_to(input logic [15:0] c);
        return c[1] ? 16'd20000 : 16'd2500;
    endfunction
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One-cycle request; returns after the answer edge
    task automatic cmd(input logic [7:0] c, input logic w, input logic [15:0] v,
            input logic [1:0] ans);
        step(1);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_write = w;
        cmd_wdata = v;
        cmd_page = 2'(rnd());
        step(1);
        cmd_valid = 1'b0;
        check("answer", 16'(ans), {14'h0, cmd_nack, cmd_ack});
    endtask
    task automatic wr_cfg(input logic [15:0] v);
        cmd(CMD_GLOBAL_CFG, 1'b1, v, 2'b01);
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 100 && busy !== 1'b0; n++) step(1);
        check("busy", 16'h0, {15'h0, busy});
    endtask
    task automatic stop_test();
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #100000;
        errors++;
        stop_test();
    end
    initial begin
        step(4);
        check("rst", 16'h3, {14'h0, busy, aux_oe});
        check("rst_to", exp_to(16'h0), bus_to);
        resetn = 1'b1;
        cmd(CMD_COMMON_STAT, 1'b0, 16'h0, 2'b01);
        check("busy_bit", 16'h0, {15'h0, cmd_rdata[6]});
        cmd(CMD_GLOBAL_CFG, 1'b1, 16'h0, 2'b10);
        wait_idle();
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 16'hfccf : rnd() & 16'hfccf;
            wr_cfg(d);
            check("pgood", 16'(d[11]), {15'h0, pgood_sel});
            check("pec", 16'(d[2]), {15'h0, pec_req});
            check("tmo", exp_to(d), bus_to);
            check("aux", 16'(!d[0]), {15'h0, aux_oe});
            cmd(CMD_GLOBAL_CFG, 1'b0, 16'h0, 2'b01);
            check("cfg", {4'h0, d[11:0]}, cmd_rdata);
        end
        for (int k = 0; k < 3; k++) begin
            d = rnd();
            cmd(8'hbd + 8'(k), 1'b1, d, 2'b01);
            cmd(8'hbd + 8'(k), 1'b0, 16'h0, 2'b01);
            check("nvm", (k == 2) ? d : {8'h0, d[7:0]}, cmd_rdata);
        end
        cmd(8'h00, 1'b0, 16'h0, 2'b10);
        wr_cfg(16'h0004);
        cmd_pec_present = 1'b0;
        cmd(CMD_GLOBAL_CFG, 1'b1, 16'h0, 2'b10);
        cmd_pec_present = 1'b1;
        wr_cfg(16'h0000);
        cmd_pec_present = 1'b0;
        cmd(CMD_GLOBAL_CFG, 1'b1, 16'h084a, 2'b01);
        cmd_pec_present = 1'b1;
        cmd(CMD_SAVE_ALL, 1'b0, 16'h0, 2'b01);
        cmd(CMD_NVM_DATA, 1'b0, 16'h0, 2'b10);
        wait_idle();
        wr_cfg(16'h0403);
        cmd(CMD_RELOAD_ALL, 1'b0, 16'h0, 2'b01);
        wait_idle();
        cmd(CMD_GLOBAL_CFG, 1'b0, 16'h0, 2'b01);
        check("reload", 16'h084a, cmd_rdata);
        for (int p = 0; p < 2; p++) begin
            wr_cfg(p ? 16'h0330 : 16'h0000);
            run_control_pin = p ? 4'h0 : 4'hf;
            step(20);
            check("run_off", 16'h0, {12'h0, en});
        end
        fault_in = 4'h1;
        step(2);
        check("flog0", 16'h0, {15'h0, flog});
        wr_cfg(16'h0080);
        check("flog1", 16'h1, {15'h0, flog});
        fault_in = 4'h0;
        for (int m = 0; m < 2; m++) begin
            wr_cfg(m ? 16'h0000 : 16'h0048);
            vin_above_on = 1'b0;
            step(2);
            check("share", 16'(!m), {15'h0, share_oe});
            clr_cnt = 0;
            vin_above_on = 1'b1;
            step(4);
            check("clear", 16'(!m), 16'(clr_cnt));
        end
        stop_test();
    end
endmodule // tsg_top_bench

//--- testbench/tsg_top_properties.sv
// Checker: port-level properties of the tracking sequencer top
`timescale 1ns/1ns
module tsg_top_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_pec_present,
    input wire logic cmd_pec_ok,
    input wire logic cmd_ack,
    input wire logic cmd_nack,
    input wire logic [15:0] cmd_rdata,
    // Fault inputs and side outputs
    input wire logic [3:0] fault_in,
    input wire logic [3:0] uv_det,
    input wire logic [3:0] uc_det,
    input wire logic pgood_deassert_source_sel,
    input wire logic pec_required,
    input wire logic [15:0] bus_timeout_cyc,
    input wire logic aux_fault_pu_oe,
    input wire logic busy
);
    import tsg_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic cfg_wr; // Config write request
    logic cfg_rd; // Config read request
    logic seen_ff; // Fault seen since reset, forces aux off
    always_ff @(posedge ref_clk) seen_ff <= resetn && (seen_ff || |(fault_in | uv_det | uc_det));
    // Decode of config requests
    always_comb begin
        cfg_wr = cmd_valid && cmd_write && cmd_code == CMD_GLOBAL_CFG;
        cfg_rd = cmd_valid && !cmd_write && cmd_code == CMD_GLOBAL_CFG;
    end
    chk_cfg_pgood: assert property (
        cmd_ack && $past(cfg_wr) |-> pgood_deassert_source_sel == $past(cmd_wdata[11]))
        else $error("pgood source select wrong");
    chk_cfg_pec: assert property (
        cmd_ack && $past(cfg_wr) |-> pec_required == $past(cmd_wdata[2]))
        else $error("pec required wrong");
    chk_cfg_timeout: assert property (
        cmd_ack && $past(cfg_wr) |-> bus_timeout_cyc ==
            ($past(cmd_wdata[1]) ? BUS_TO_CYC * LONG_TO_MUL : BUS_TO_CYC))
        else $error("bus timeout wrong");
    chk_aux_pullup: assert property (
        cmd_ack && $past(cfg_wr) |-> aux_fault_pu_oe == (!$past(cmd_wdata[0]) && !seen_ff))
        else $error("aux pull-up wrong");
    chk_rsvd_zero: assert property (
        cmd_ack && $past(cfg_rd) |-> cmd_rdata[15:12] == 4'h0)
        else $error("reserved bits not zero");
    chk_busy_refuse: assert property (
        cmd_valid && busy && cmd_code != CMD_COMMON_STAT |=> cmd_nack && !cmd_ack)
        else $error("command not refused while busy");
    chk_stat_busy: assert property (
        cmd_valid && !cmd_write && cmd_code == CMD_COMMON_STAT && cmd_pec_present && cmd_pec_ok
        |=> cmd_ack && cmd_rdata[6] == !$past(busy))
        else $error("status read wrong");
    chk_save_busy: assert property (
        cmd_valid && !busy && !cmd_write && (cmd_code == CMD_SAVE_ALL || cmd_code == CMD_RELOAD_ALL)
        ##1 cmd_ack |-> busy [*8] ##[1:20] !busy)
        else $error("busy wrong during save or reload");
    chk_boot_busy: assert property (
        $rose(resetn) |-> busy ##[1:30] !busy)
        else $error("boot reload busy wrong");
    chk_nvm_decode: assert property (
        cmd_valid && !busy && cmd_pec_present && cmd_pec_ok && (cmd_code == CMD_NVM_UNLOCK
        || cmd_code == CMD_NVM_ERASE || cmd_code == CMD_NVM_DATA) |=> cmd_ack)
        else $error("store access not decoded");
endmodule // tsg_top_properties
bind tsg_top tsg_top_properties u_tsg_top_properties (
    .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_pec_present(cmd_pec_present),
    .cmd_pec_ok(cmd_pec_ok), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata),
    .fault_in(fault_in), .uv_det(uv_det), .uc_det(uc_det),
    .pgood_deassert_source_sel(pgood_deassert_source_sel),
    .pec_required(pec_required), .bus_timeout_cyc(bus_timeout_cyc),
    .aux_fault_pu_oe(aux_fault_pu_oe), .busy(busy));
